//--- design/usl_defines.svh
// Register map, field positions, reset values and timing for the status/loopback/baud block
`ifndef USL_DEFINES_SVH
`define USL_DEFINES_SVH
`define USL_IDX_DATA       6'h00
`define USL_IDX_LINE_CTRL  6'h03
`define USL_IDX_MODEM_CTRL 6'h04
`define USL_IDX_LINE_STAT  6'h05
`define USL_IDX_MODEM_STAT 6'h06
`define USL_IDX_SCRATCH    6'h07
`define USL_IDX_DIV_LOW    6'h08
`define USL_IDX_DIV_HIGH   6'h09
`define USL_IDX_PRESCALE   6'h0a
`define USL_MC_DTR         0
`define USL_MC_RTS         1
`define USL_MC_USER_OUT_A        2
`define USL_MC_USER_OUT_B_IRQ_EN        3
`define USL_MC_LOOP        4
`define USL_LC_PAR_EN      3
`define USL_LC_EVEN        4
`define USL_RST_DIV        16'h0001
`define USL_RST_BYTE       8'h00
`define USL_SYS_HZ         64'd40000000
`define USL_F_STD          64'd1846200
`define USL_F_115K         64'd1843200
`define USL_F_230K         64'd3686400
`define USL_F_460K         64'd7372800
`define USL_PHASE(f)       24'(((f) << 24) / `USL_SYS_HZ)
`define USL_HALF_BIT       4'h8
`define USL_MID_BIT        4'h7
`define USL_LAST_SUB       4'hf
`define USL_RESP_OKAY      2'b00
`define USL_RESP_SLVERR    2'b10
`endif

//--- design/usl_pkg.sv
// Types for the status/loopback/baud block
package usl_pkg;
  typedef enum logic [2:0] {
    USL_TX_IDLE = 3'b000, USL_TX_START = 3'b001, USL_TX_DATA = 3'b010,
    USL_TX_PAR = 3'b011, USL_TX_STOP = 3'b100
  } usl_tx_st_t;
  typedef enum logic [2:0] {
    USL_RX_IDLE = 3'b000, USL_RX_START = 3'b001, USL_RX_DATA = 3'b010,
    USL_RX_PAR = 3'b011, USL_RX_STOP = 3'b100, USL_RX_BRK = 3'b101
  } usl_rx_st_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [2:0] err;
  } usl_push_t;
  typedef struct packed {
    logic       nonempty;
    logic       full;
    logic [2:0] head_err;
    logic       err_any;
  } usl_fifo_stat_t;
  typedef struct packed {
    logic [4:0]  modem_control;
    logic        par_en;
    logic        even;
    logic [7:0]  scratch;
    logic [15:0] div;
    logic [1:0]  presel;
    logic [23:0] acc;
    logic        pre_tick;
    logic [15:0] bcnt;
    logic        bout;
    logic        tick16;
    logic [7:0]  tx_hold_reg;
    logic        thr_full;
    usl_tx_st_t  tx_st;
    logic [3:0]  tx_sub;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_par;
    logic        tx_line;
    usl_rx_st_t  rx_st;
    logic [3:0]  rx_sub;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic        rx_zero;
    logic [7:0]  rx_buf;
    logic        dr;
    logic [3:0]  err;
    logic [3:0]  ms_prev;
    logic [3:0]  msd;
    usl_push_t   push;
    logic        pop;
    logic        aw_got;
    logic [5:0]  aw_idx;
    logic        w_got;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } usl_state_t;
endpackage

//--- design/usl_serial_status.sv
// Loopback, line/modem status, scratch and baud divider with an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "usl_defines.svh"

// Notes on behaviour
// - Loopback drives serial_out high, ignores serial_in, feeds transmitter into receiver
// - Loopback routes the four control bits to the status inputs; pins held high
// - Loopback modem events come from control bits, still gated by enables
// - Data ready sets when a character lands, clears when all data read
// - Overrun on unread buffer or full FIFO; FIFO drops the character; clear on read
// - Parity error sets on bad parity, clears on line status read
// - FIFO mode adds stored errors once their character is at head; they stay until line status read
// - Framing error sets when stop bit samples low, clears on line status read
// - After framing error without break the low stop is taken as next start bit
// - Break sets when input low for a whole character, clears on read
// - Break stores one zero character; restart needs half a bit of high
// - Any of the four errors requests a line status interrupt when enabled
// - Hold-empty sets on transfer to shifter, clears on write, requests interrupt
// - All-empty is high exactly when hold and shift registers are both empty
// - Top status bit is zero outside FIFO mode, else any error in FIFO
// - Change flags set on input change or ring trailing edge, clear on read
// - Upper modem status bits show inverted inputs, or control bits in loopback
// - Scratch is eight bits of storage with no effect on the port
// - Divider divides by sixteen-bit divisor, output sixteen times baud rate
// - Writing either divisor byte reloads the baud counter at once
// - Divisor 0 divides by 3, 1 inverts, 2 halves, else low two counts
// - System clock pre-divided to the selected reference before the divider
// - Terminal-ready and request-to-send pins are the inverted control bits outside loopback
// - Second user output enables the serial interrupt pin driver
module usl_serial_status (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 serial_in,
  output logic                      serial_out,
  input  wire logic                 clear_to_send_n,
  input  wire logic                 set_ready_in_n,
  input  wire logic                 ring_in_n,
  input  wire logic                 carrier_in_n,
  output logic                      terminal_ready_out_n,
  output logic                      request_send_out_n,
  input  wire logic                 fifo_mode,
  input  wire usl_pkg::usl_fifo_stat_t rx_fifo,
  output usl_pkg::usl_push_t        rx_push,
  output logic                      rx_pop,
  input  wire logic [3:0]           irq_enable,
  output logic                      line_irq_req,
  output logic                      tx_hold_empty_irq_req,
  output logic                      modem_irq_req,
  input  wire logic                 serial_irq,
  output logic                      serial_irq_out,
  output logic                      serial_irq_oe,
  output logic                      baud16_out
);
  usl_pkg::usl_state_t s_ff;
  usl_pkg::usl_state_t nxt_s;
  logic                loop;
  logic                rx_in;
  logic [3:0]          ms_now;
  logic [7:0]          line_status;
  logic [7:0]          modem_status;
  logic                tx_all_empty;
  logic [15:0]         div_eff;
  logic [23:0]         phase;
  logic                rx_done;

  assign loop = s_ff.modem_control[`USL_MC_LOOP];
  assign rx_in = loop ? s_ff.tx_line : serial_in;
  assign serial_out = loop | s_ff.tx_line;
  assign terminal_ready_out_n = loop | ~s_ff.modem_control[`USL_MC_DTR];
  assign request_send_out_n = loop | ~s_ff.modem_control[`USL_MC_RTS];
  // Active-high view in MODEM_STATUS order: cts, dsr, ri, dcd
  assign ms_now = loop ? {s_ff.modem_control[`USL_MC_USER_OUT_B_IRQ_EN], s_ff.modem_control[`USL_MC_USER_OUT_A],
                          s_ff.modem_control[`USL_MC_DTR], s_ff.modem_control[`USL_MC_RTS]}
                       : ~{carrier_in_n, ring_in_n, set_ready_in_n, clear_to_send_n};
  assign modem_status = {ms_now, s_ff.msd};
  assign tx_all_empty = !s_ff.thr_full && s_ff.tx_st == usl_pkg::USL_TX_IDLE;
  assign line_status = {fifo_mode & rx_fifo.err_any, tx_all_empty, !s_ff.thr_full,
                s_ff.err, s_ff.dr};
  assign line_irq_req = irq_enable[2] & (|s_ff.err);
  assign tx_hold_empty_irq_req = irq_enable[1] & !s_ff.thr_full;
  assign modem_irq_req = irq_enable[3] & (|s_ff.msd);
  assign serial_irq_out = serial_irq;
  assign serial_irq_oe = s_ff.modem_control[`USL_MC_USER_OUT_B_IRQ_EN];
  assign div_eff = (s_ff.div == 16'h0000) ? 16'h0003 : s_ff.div;
  assign rx_push = s_ff.push;
  assign rx_pop = s_ff.pop;
  assign baud16_out = s_ff.bout;
  assign s_axi_awready = !s_ff.aw_got && !s_ff.bvalid;
  assign s_axi_wready = !s_ff.w_got && !s_ff.bvalid;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = !s_ff.rvalid;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rresp = s_ff.rresp;
  assign s_axi_rdata = {24'h000000, s_ff.rdata};

  always_comb begin
    case (s_ff.presel)
      2'b01:   phase = `USL_PHASE(`USL_F_115K);
      2'b10:   phase = `USL_PHASE(`USL_F_230K);
      2'b11:   phase = `USL_PHASE(`USL_F_460K);
      default: phase = `USL_PHASE(`USL_F_STD);
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    rx_done = 1'b0;
    nxt_s.push.valid = 1'b0;
    nxt_s.pop = 1'b0;
    // Phase accumulator gives an even-on-average reference tick from the system clock
    {nxt_s.pre_tick, nxt_s.acc} = {1'b0, s_ff.acc} + {1'b0, phase};
    nxt_s.tick16 = 1'b0;
    if (s_ff.pre_tick) begin
      if (s_ff.bcnt == 16'h0000) begin
        nxt_s.bcnt = div_eff - 16'h0001;
        nxt_s.tick16 = 1'b1;
      end else begin
        nxt_s.bcnt = s_ff.bcnt - 16'h0001;
      end
      if (div_eff == 16'h0001) begin
        nxt_s.bout = ~s_ff.bout;
      end else if (div_eff == 16'h0002) begin
        nxt_s.bout = (s_ff.bcnt == 16'h0000);
      end else begin
        nxt_s.bout = (s_ff.bcnt != 16'h0000) && (nxt_s.bcnt < div_eff - 16'h0002);
      end
    end
    // Transmitter: loads from the hold register when idle
    if (s_ff.tx_st == usl_pkg::USL_TX_IDLE) begin
      nxt_s.tx_line = 1'b1;
      if (s_ff.thr_full) begin
        nxt_s.tx_sh = s_ff.tx_hold_reg;
        nxt_s.thr_full = 1'b0;
        nxt_s.tx_par = ~s_ff.even;
        nxt_s.tx_sub = 4'h0;
        nxt_s.tx_st = usl_pkg::USL_TX_START;
      end
    end else if (s_ff.tick16) begin
      nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
      case (s_ff.tx_st)
        usl_pkg::USL_TX_START: nxt_s.tx_line = 1'b0;
        usl_pkg::USL_TX_DATA:  nxt_s.tx_line = s_ff.tx_sh[0];
        usl_pkg::USL_TX_PAR:   nxt_s.tx_line = s_ff.tx_par;
        default:               nxt_s.tx_line = 1'b1;
      endcase
      if (s_ff.tx_sub == `USL_LAST_SUB) begin
        case (s_ff.tx_st)
          usl_pkg::USL_TX_START: begin
            nxt_s.tx_st = usl_pkg::USL_TX_DATA;
            nxt_s.tx_bit = 3'h0;
          end
          usl_pkg::USL_TX_DATA: begin
            nxt_s.tx_par = s_ff.tx_par ^ s_ff.tx_sh[0];
            nxt_s.tx_sh = {1'b0, s_ff.tx_sh[7:1]};
            nxt_s.tx_bit = s_ff.tx_bit + 3'h1;
            if (s_ff.tx_bit == 3'h7) begin
              nxt_s.tx_st = s_ff.par_en ? usl_pkg::USL_TX_PAR : usl_pkg::USL_TX_STOP;
            end
          end
          usl_pkg::USL_TX_PAR:   nxt_s.tx_st = usl_pkg::USL_TX_STOP;
          default:               nxt_s.tx_st = usl_pkg::USL_TX_IDLE;
        endcase
      end
    end
    // Bus write: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata[7:0];
      nxt_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `USL_RESP_OKAY;
      case (s_ff.aw_idx)
        `USL_IDX_DATA: begin
          if (s_ff.wstrb0) begin
            nxt_s.tx_hold_reg = s_ff.wdata;
            nxt_s.thr_full = 1'b1;
          end
        end
        `USL_IDX_LINE_CTRL: begin
          if (s_ff.wstrb0) begin
            nxt_s.par_en = s_ff.wdata[`USL_LC_PAR_EN];
            nxt_s.even = s_ff.wdata[`USL_LC_EVEN];
          end
        end
        `USL_IDX_MODEM_CTRL: if (s_ff.wstrb0) nxt_s.modem_control = s_ff.wdata[4:0];
        `USL_IDX_SCRATCH:    if (s_ff.wstrb0) nxt_s.scratch = s_ff.wdata;
        `USL_IDX_DIV_LOW: begin
          if (s_ff.wstrb0) begin
            nxt_s.div[7:0] = s_ff.wdata;
            nxt_s.bcnt = {s_ff.div[15:8], s_ff.wdata};
          end
        end
        `USL_IDX_DIV_HIGH: begin
          if (s_ff.wstrb0) begin
            nxt_s.div[15:8] = s_ff.wdata;
            nxt_s.bcnt = {s_ff.wdata, s_ff.div[7:0]};
          end
        end
        `USL_IDX_PRESCALE:   if (s_ff.wstrb0) nxt_s.presel = s_ff.wdata[1:0];
        `USL_IDX_LINE_STAT, `USL_IDX_MODEM_STAT: ;
        default:             nxt_s.bresp = `USL_RESP_SLVERR;
      endcase
    end
    // Bus read: clearing effects come first so that events below win
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = `USL_RESP_OKAY;
      case (s_axi_araddr[7:2])
        `USL_IDX_DATA: begin
          nxt_s.rdata = fifo_mode ? 8'h00 : s_ff.rx_buf;
          nxt_s.dr = 1'b0;
          nxt_s.pop = fifo_mode;
        end
        `USL_IDX_LINE_CTRL:  nxt_s.rdata = {3'h0, s_ff.even, s_ff.par_en, 3'h0};
        `USL_IDX_MODEM_CTRL: nxt_s.rdata = {3'h0, s_ff.modem_control};
        `USL_IDX_LINE_STAT: begin
          nxt_s.rdata = line_status;
          nxt_s.err = 4'h0;
        end
        `USL_IDX_MODEM_STAT: begin
          nxt_s.rdata = modem_status;
          nxt_s.msd = 4'h0;
        end
        `USL_IDX_SCRATCH:    nxt_s.rdata = s_ff.scratch;
        `USL_IDX_DIV_LOW:    nxt_s.rdata = s_ff.div[7:0];
        `USL_IDX_DIV_HIGH:   nxt_s.rdata = s_ff.div[15:8];
        `USL_IDX_PRESCALE:   nxt_s.rdata = {6'h00, s_ff.presel};
        default: begin
          nxt_s.rdata = 8'h00;
          nxt_s.rresp = `USL_RESP_SLVERR;
        end
      endcase
    end
    // Modem change flags, set after the clear above
    nxt_s.ms_prev = ms_now;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        if (s_ff.ms_prev[i] && !ms_now[i]) nxt_s.msd[i] = 1'b1;
      end else if (s_ff.ms_prev[i] != ms_now[i]) begin
        nxt_s.msd[i] = 1'b1;
      end
    end
    // Receiver at sixteen samples per bit
    if (s_ff.tick16) begin
      nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
      case (s_ff.rx_st)
        usl_pkg::USL_RX_IDLE: begin
          nxt_s.rx_sub = 4'h0;
          if (!rx_in) nxt_s.rx_st = usl_pkg::USL_RX_START;
        end
        usl_pkg::USL_RX_START: begin
          if (s_ff.rx_sub == `USL_MID_BIT) begin
            nxt_s.rx_sub = 4'h0;
            nxt_s.rx_bit = 3'h0;
            nxt_s.rx_par = ~s_ff.even;
            nxt_s.rx_zero = 1'b1;
            nxt_s.rx_st = rx_in ? usl_pkg::USL_RX_IDLE : usl_pkg::USL_RX_DATA;
          end
        end
        usl_pkg::USL_RX_DATA: begin
          if (s_ff.rx_sub == `USL_LAST_SUB) begin
            nxt_s.rx_sh = {rx_in, s_ff.rx_sh[7:1]};
            nxt_s.rx_par = s_ff.rx_par ^ rx_in;
            nxt_s.rx_zero = s_ff.rx_zero & !rx_in;
            nxt_s.rx_bit = s_ff.rx_bit + 3'h1;
            if (s_ff.rx_bit == 3'h7) begin
              nxt_s.rx_st = s_ff.par_en ? usl_pkg::USL_RX_PAR : usl_pkg::USL_RX_STOP;
            end
          end
        end
        usl_pkg::USL_RX_PAR: begin
          if (s_ff.rx_sub == `USL_LAST_SUB) begin
            nxt_s.rx_par = s_ff.rx_par ^ rx_in;
            nxt_s.rx_zero = s_ff.rx_zero & !rx_in;
            nxt_s.rx_st = usl_pkg::USL_RX_STOP;
          end
        end
        usl_pkg::USL_RX_STOP: begin
          if (s_ff.rx_sub == `USL_LAST_SUB) begin
            rx_done = 1'b1;
            nxt_s.rx_sub = 4'h0;
            nxt_s.push.err = {!rx_in && s_ff.rx_zero, !rx_in, s_ff.par_en && s_ff.rx_par};
            nxt_s.push.data = (!rx_in && s_ff.rx_zero) ? 8'h00 : s_ff.rx_sh;
            if (!rx_in && s_ff.rx_zero) begin
              nxt_s.rx_st = usl_pkg::USL_RX_BRK;
            end else if (!rx_in) begin
              // Low stop is taken as the next start, already at mid-bit
              nxt_s.rx_st = usl_pkg::USL_RX_START;
              nxt_s.rx_sub = `USL_MID_BIT;
            end else begin
              nxt_s.rx_st = usl_pkg::USL_RX_IDLE;
            end
          end
        end
        usl_pkg::USL_RX_BRK: begin
          nxt_s.rx_sub = rx_in ? s_ff.rx_sub + 4'h1 : 4'h0;
          if (rx_in && s_ff.rx_sub == `USL_HALF_BIT - 4'h1) begin
            nxt_s.rx_st = usl_pkg::USL_RX_IDLE;
          end
        end
        default: nxt_s.rx_st = usl_pkg::USL_RX_IDLE;
      endcase
    end
    // Character completion sets status after any clearing read
    if (rx_done) begin
      if (fifo_mode) begin
        if (rx_fifo.full) begin
          nxt_s.err[0] = 1'b1;
        end else begin
          nxt_s.push.valid = 1'b1;
        end
      end else begin
        if (s_ff.dr) nxt_s.err[0] = 1'b1;
        nxt_s.dr = 1'b1;
        nxt_s.rx_buf = nxt_s.push.data;
        nxt_s.err[3:1] = s_ff.err[3:1] | nxt_s.push.err;
      end
    end
    // FIFO mode: head character errors are ORed into the held flags, data ready follows occupancy
    if (fifo_mode) begin
      nxt_s.err[3:1] = nxt_s.err[3:1] | rx_fifo.head_err;
      nxt_s.dr = rx_fifo.nonempty;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.div <= `USL_RST_DIV;
      s_ff.scratch <= `USL_RST_BYTE;
      s_ff.tx_line <= 1'b1;
      s_ff.ms_prev <= 4'h0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  chk_loop_pins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    loop |-> serial_out && terminal_ready_out_n && request_send_out_n)
    else $error("loopback pins not held high");
  chk_loop_msr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    loop |-> modem_status[7:4] == {s_ff.modem_control[3], s_ff.modem_control[2], s_ff.modem_control[0], s_ff.modem_control[1]})
    else $error("loopback modem status mismatch");
  chk_dr_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rx_done && !fifo_mode) |=> s_ff.dr && s_ff.rx_buf == $past(nxt_s.rx_buf))
    else $error("data ready not set on character");
  chk_overrun_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rx_done && !fifo_mode && s_ff.dr) |=> s_ff.err[0])
    else $error("overrun not flagged");
  chk_lsr_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == `USL_IDX_LINE_STAT
     && !rx_done && !fifo_mode) |=> s_ff.err == 4'h0 && s_ff.rvalid)
    else $error("line status read did not clear errors");
  chk_tx_hold_empty_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_ff.aw_got && s_ff.w_got && s_ff.wstrb0 && s_ff.aw_idx == `USL_IDX_DATA)
    |=> !line_status[5] && !line_status[6])
    else $error("hold empty not cleared by write");
  chk_msr_delta: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($changed(ms_now[0]) || $changed(ms_now[3])) |=> (s_ff.msd[0] || s_ff.msd[3]))
    else $error("modem change not flagged");
  chk_div_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_ff.aw_got && s_ff.w_got && s_ff.wstrb0 && s_ff.aw_idx == `USL_IDX_DIV_LOW)
    |=> s_ff.bcnt == s_ff.div)
    else $error("divisor write did not reload counter");
  chk_brk_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_ff.rx_st == usl_pkg::USL_RX_BRK && !rx_in) |=> s_ff.rx_st == usl_pkg::USL_RX_BRK)
    else $error("break left while line low");
  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    serial_irq_oe == s_ff.modem_control[`USL_MC_USER_OUT_B_IRQ_EN])
    else $error("interrupt pin enable wrong");
  cov_loop_char: cover property (@(posedge sys_clk) disable iff (sys_rst)
    loop && rx_done);
  cov_break: cover property (@(posedge sys_clk) disable iff (sys_rst)
    s_ff.rx_st == usl_pkg::USL_RX_BRK);
  cov_frame_err: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rx_done && !rx_in && !s_ff.rx_zero);
endmodule

//--- sim/usl_modem_model.sv
// Modem and terminal model on the serial line and handshake inputs
`timescale 1ns/1ps
module usl_modem_model (
  input  wire logic       line_low,
  input  wire logic [3:0] lines_n,
  output logic            serial_in,
  output logic            clear_to_send_n,
  output logic            set_ready_in_n,
  output logic            ring_in_n,
  output logic            carrier_in_n
);
  // Line idles at mark, so a break always ends with the high time a restart needs
  assign serial_in = ~line_low;
  assign clear_to_send_n = lines_n[0];
  assign set_ready_in_n = lines_n[1];
  assign ring_in_n = lines_n[2];
  assign carrier_in_n = lines_n[3];
endmodule

//--- sim/tb.sv
// Bench for the status, loopback and baud block
`timescale 1ns/1ps
`include "usl_defines.svh"
module tb;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, d;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ser_in, ser_out, dtr_n, rts_n;
  logic [1:0]  bresp, rresp, r;
  logic        line_low = 1'b0, cts_n, dsr_n, ri_n, dcd_n, l_irq, t_irq, m_irq, irq_oe;
  logic [3:0]  lines_n = 4'hf;
  int          n_errors = 0, check_count = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  usl_serial_status u_usl_serial_status (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in(ser_in), .serial_out(ser_out), .clear_to_send_n(cts_n),
    .set_ready_in_n(dsr_n), .ring_in_n(ri_n), .carrier_in_n(dcd_n),
    .terminal_ready_out_n(dtr_n), .request_send_out_n(rts_n), .fifo_mode(1'b0),
    .rx_fifo('0), .rx_push(), .rx_pop(), .irq_enable(4'hf), .line_irq_req(l_irq),
    .tx_hold_empty_irq_req(t_irq), .modem_irq_req(m_irq), .serial_irq(1'b1), .serial_irq_out(),
    .serial_irq_oe(irq_oe), .baud16_out());
  usl_modem_model u_usl_modem_model (.line_low(line_low), .lines_n(lines_n),
    .serial_in(ser_in), .clear_to_send_n(cts_n), .set_ready_in_n(dsr_n),
    .ring_in_n(ri_n), .carrier_in_n(dcd_n));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    @(posedge sys_clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge sys_clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready  <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx);
    @(posedge sys_clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready  <= 1'b0;
  endtask
  task automatic rc(input string what, input logic [5:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(what, d, exp);
  endtask
  task automatic t_regs();
    rc("lsr idle", `USL_IDX_LINE_STAT, 8'h60);
    chk("tx_hold_empty irq", {7'h0, t_irq}, 8'h01);
    wr(`USL_IDX_SCRATCH, 8'ha5);
    rc("scratch", `USL_IDX_SCRATCH, 8'ha5);
    rc("lsr after scratch", `USL_IDX_LINE_STAT, 8'h60);
    wr(`USL_IDX_DIV_LOW, 8'h01);
    rc("divisor low", `USL_IDX_DIV_LOW, 8'h01);
    rd(6'h3f);
    chk("unmapped resp", {6'h0, r}, {6'h0, `USL_RESP_SLVERR});
    $display("test registers done");
  endtask
  task automatic t_modem();
    rd(`USL_IDX_MODEM_STAT);
    lines_n <= 4'he;
    for (int i = 0; i < 20 && m_irq !== 1'b1; i++) @(posedge sys_clk);
    rc("msr cts change", `USL_IDX_MODEM_STAT, 8'h11);
    rc("msr cleared", `USL_IDX_MODEM_STAT, 8'h10);
    lines_n <= 4'ha;
    repeat (8) @(posedge sys_clk);
    rc("msr ring low", `USL_IDX_MODEM_STAT, 8'h50);
    lines_n <= 4'he;
    repeat (8) @(posedge sys_clk);
    rc("msr ring trail", `USL_IDX_MODEM_STAT, 8'h14);
    $display("test modem status done");
  endtask
  task automatic t_loop();
    wr(`USL_IDX_PRESCALE, 8'h03);
    line_low <= 1'b1;
    wr(`USL_IDX_MODEM_CTRL, 8'h1f);
    chk("pins in loop", {5'h0, ser_out, dtr_n, rts_n}, 8'h07);
    chk("irq oe", {7'h0, irq_oe}, 8'h01);
    rd(`USL_IDX_MODEM_STAT);
    rc("msr loop", `USL_IDX_MODEM_STAT, 8'hf0);
    wr(`USL_IDX_DATA, 8'h3c);
    rd(`USL_IDX_LINE_STAT);
    chk("tx_all_empty busy", {7'h0, d[6]}, 8'h00);
    for (int i = 0; i < 400 && d[0] !== 1'b1; i++) rd(`USL_IDX_LINE_STAT);
    chk("lsr char", d, 8'h21);
    rc("loop data", `USL_IDX_DATA, 8'h3c);
    // The stop bit is still being sent for six sample ticks after the receiver takes it
    repeat (60) @(posedge sys_clk);
    rc("lsr empty", `USL_IDX_LINE_STAT, 8'h60);
    wr(`USL_IDX_MODEM_CTRL, 8'h03);
    chk("pins out", {5'h0, irq_oe, dtr_n, rts_n}, 8'h00);
    $display("test loopback done");
  endtask
  task automatic t_break();
    d = 8'h00;
    for (int i = 0; i < 400 && d[4] !== 1'b1; i++) rd(`USL_IDX_LINE_STAT);
    chk("lsr break", d, 8'h79);
    rc("lsr break clr", `USL_IDX_LINE_STAT, 8'h61);
    line_low <= 1'b0;
    rc("break char", `USL_IDX_DATA, 8'h00);
    $display("test break done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_modem();
    t_loop();
    t_break();
    stop_test();
  end
endmodule
